// ---- hdl/txy_pkg.sv ----
package txy_pkg;

    // register indexes; the byte address is four times the index
    localparam int       TXY_IDX_W      = 8;
    localparam logic [7:0] TXY_IDX_T2   = 8'h22;
    localparam logic [7:0] TXY_IDX_MODE = 8'h23;
    localparam logic [7:0] TXY_IDX_TX   = 8'h25;
    localparam logic [7:0] TXY_IDX_TY   = 8'h27;
    localparam logic [7:0] TXY_IDX_CSS  = 8'h28;

    // timer slots
    localparam int TXY_NUM_TIMERS = 3;
    localparam int TXY_T2         = 0;
    localparam int TXY_TX         = 1;
    localparam int TXY_TY         = 2;

    // timer xy mode register fields
    localparam int TXY_MODE_X_LSB = 0;
    localparam int TXY_EDGE_X_BIT = 2;
    localparam int TXY_STOP_X_BIT = 3;
    localparam int TXY_MODE_Y_LSB = 4;
    localparam int TXY_EDGE_Y_BIT = 6;
    localparam int TXY_STOP_Y_BIT = 7;

    // count source select fields
    localparam int TXY_CSS_W      = 3;
    localparam int TXY_CSS_X_BIT  = 0;
    localparam int TXY_CSS_Y_BIT  = 1;
    localparam int TXY_CSS_12_BIT = 2;

    // reset values
    localparam logic [7:0] TXY_CNT_RST  = 8'hff;
    localparam logic [7:0] TXY_MODE_RST = 8'h00;
    localparam logic [2:0] TXY_CSS_RST  = 3'h0;

    // source dividers
    localparam int TXY_DIV_SLOW = 16;
    localparam int TXY_DIV_FAST = 2;
    localparam int TXY_DIV_W    = $clog2(TXY_DIV_SLOW);

    // synchronised pin inputs
    localparam int TXY_SYNC_W    = 4;
    localparam int TXY_SYNC_PINX = 0;
    localparam int TXY_SYNC_PINY = 1;
    localparam int TXY_SYNC_SUB  = 2;
    localparam int TXY_SYNC_LOW  = 3;

    typedef enum logic [1:0] {
        TXY_MODE_TIMER,
        TXY_MODE_PULSE,
        TXY_MODE_EVENT,
        TXY_MODE_WIDTH
    } txy_mode_t;

    typedef struct packed {
        txy_mode_t mode;
        logic      edge_sel;
        logic      stop;
    } txy_tmr_ctl_t;

    typedef struct packed {
        logic [7:0] count;
        logic       underflow;
        logic       pin_level;
        logic       pin_oe;
        logic       pin_irq;
    } txy_tmr_stat_t;

endpackage

// ---- hdl/txy_timer.sv ----
`timescale 1ns/1ps
module txy_timer
    import txy_pkg::*;
#(
    parameter int         CNT_W     = 8,
    parameter logic [7:0] RESET_VAL = TXY_CNT_RST
) (
    input  wire logic          ref_clk_in,
    input  wire logic          rst_in,
    input  wire logic          clk_en_in,
    input  wire logic          tick_in,
    input  wire logic          load_in,
    input  wire logic [7:0]    load_val_in,
    input  wire txy_tmr_ctl_t  ctl_in,
    input  wire logic          pin_in,
    output txy_tmr_stat_t      stat_out
);

    if (CNT_W != 8) begin : g_bad_width
        $error("txy_timer: count registers are eight bits wide");
    end

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] latch;
        logic       pin_prev;
        logic       level;
        logic       oe;
        logic       uf;
        logic       pin_irq;
    } txy_tmr_state_t;

    txy_tmr_state_t q;
    txy_tmr_state_t d;

    always_comb begin
        logic rise;
        logic fall;
        logic step;
        rise = 1'b0;
        fall = 1'b0;
        step = 1'b0;
        d = q;
        d.uf = 1'b0;
        d.pin_prev = pin_in;
        rise = pin_in & ~q.pin_prev;
        fall = ~pin_in & q.pin_prev;
        d.pin_irq = ctl_in.edge_sel ? rise : fall;
        unique case (ctl_in.mode)
            TXY_MODE_TIMER: step = tick_in;
            TXY_MODE_PULSE: step = tick_in;
            TXY_MODE_EVENT: step = ctl_in.edge_sel ? fall : rise;
            TXY_MODE_WIDTH: step = tick_in & (pin_in != ctl_in.edge_sel);
        endcase
        step = step & ~ctl_in.stop;
        if (load_in) begin
            d.cnt   = load_val_in;
            d.latch = load_val_in;
        end else if (step) begin
            if (q.cnt == 8'h00) begin
                d.cnt = q.latch;
                d.uf  = 1'b1;
                if (ctl_in.mode == TXY_MODE_PULSE) begin
                    d.level = ~q.level;
                end
            end else begin
                d.cnt = q.cnt - 8'h01;
            end
        end
        // start level outside pulse mode and on its first cycle, so mode and edge written together agree
        if (ctl_in.mode != TXY_MODE_PULSE || !q.oe) begin
            d.level = ~ctl_in.edge_sel;
        end
        d.oe = (ctl_in.mode == TXY_MODE_PULSE);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            q.cnt      <= RESET_VAL;
            q.latch    <= RESET_VAL;
            q.pin_prev <= 1'b0;
            q.level    <= 1'b1;
            q.oe       <= 1'b0;
            q.uf       <= 1'b0;
            q.pin_irq  <= 1'b0;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    assign stat_out.count     = q.cnt;
    assign stat_out.underflow = q.uf;
    assign stat_out.pin_level = q.level;
    assign stat_out.pin_oe    = q.oe;
    assign stat_out.pin_irq   = q.pin_irq;

endmodule

// ---- hdl/txy_top.sv ----
// Function
// - count write loads counter and latch together
// - each count register is eight bits
// - select bit 0: divide by 16 or 2
// - select bit 1: divide by 16 or 2
// - select bit 2: path from /16 or subclock
// - select bits 3 to 7 read zero
// - mode bits 1:0 pick timer X mode
// - mode bits 5:4 pick timer Y mode
// - mode bit 3 stops timer X
// - mode bit 7 stops timer Y
// - edge bits 2 and 6 act per mode
// - edge bit picks pin interrupt edge
// - pulse output starts high on bit 0
// - event mode counts rising on bit 0
// - width mode measures high on bit 0
`timescale 1ns/1ps
module txy_top
    import txy_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        clk_en_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        sub_clk_in,
    input  wire logic        low_speed_in,
    input  wire logic        counter_pin_x_in,
    output logic             counter_pin_x_out,
    output logic             counter_pin_x_oe_out,
    input  wire logic        counter_pin_y_in,
    output logic             counter_pin_y_out,
    output logic             counter_pin_y_oe_out,
    output logic             timer_2_irq_out,
    output logic             timer_x_irq_out,
    output logic             timer_y_irq_out,
    output logic             counter_pin_x_irq_out,
    output logic             counter_pin_y_irq_out
);

    typedef struct packed {
        logic [TXY_SYNC_W-1:0] s1;
        logic [TXY_SYNC_W-1:0] s2;
        logic [TXY_SYNC_W-1:0] s3;
        logic [TXY_SYNC_W-1:0] filt;
        logic                  sub_prev;
        logic [TXY_DIV_W-1:0]  div;
        logic [7:0]            mode;
        logic [TXY_CSS_W-1:0]  css;
        logic                  wr_pend;
        logic                  rd_pend;
        logic [TXY_IDX_W-1:0]  idx;
        logic                  hready;
        logic [31:0]           hrdata;
    } txy_top_state_t;

    localparam logic [TXY_DIV_W-1:0] DIV_SLOW_LAST = TXY_DIV_W'(TXY_DIV_SLOW - 1);
    localparam logic [TXY_DIV_W-1:0] DIV_FAST_MASK = TXY_DIV_W'(TXY_DIV_FAST - 1);
    localparam logic [TXY_IDX_W-1:0] CNT_IDX [TXY_NUM_TIMERS] = '{TXY_IDX_T2, TXY_IDX_TX, TXY_IDX_TY};

    txy_top_state_t q;
    txy_top_state_t d;

    logic                  sub_tick;
    logic                  base_tick;
    logic                  div_slow_tick;
    logic                  div_fast_tick;
    logic                  addr_ok;
    logic                  take;
    logic [TXY_SYNC_W-1:0] raw_pins;

    logic          tick     [TXY_NUM_TIMERS];
    logic          load     [TXY_NUM_TIMERS];
    txy_tmr_ctl_t  ctl      [TXY_NUM_TIMERS];
    logic          pin_sync [TXY_NUM_TIMERS];
    txy_tmr_stat_t stat     [TXY_NUM_TIMERS];

    assign raw_pins[TXY_SYNC_PINX] = counter_pin_x_in;
    assign raw_pins[TXY_SYNC_PINY] = counter_pin_y_in;
    assign raw_pins[TXY_SYNC_SUB]  = sub_clk_in;
    assign raw_pins[TXY_SYNC_LOW]  = low_speed_in;

    // source clocking: main clock rate, or subclock edges in low-speed mode
    assign sub_tick      = q.filt[TXY_SYNC_SUB] & ~q.sub_prev;
    assign base_tick     = q.filt[TXY_SYNC_LOW] ? sub_tick : 1'b1;
    assign div_slow_tick = base_tick & (q.div == DIV_SLOW_LAST);
    assign div_fast_tick = base_tick & ((q.div & DIV_FAST_MASK) == DIV_FAST_MASK);

    assign tick[TXY_T2] = q.css[TXY_CSS_12_BIT] ? sub_tick : div_slow_tick;
    assign tick[TXY_TX] = q.css[TXY_CSS_X_BIT] ? div_fast_tick : div_slow_tick;
    assign tick[TXY_TY] = q.css[TXY_CSS_Y_BIT] ? div_fast_tick : div_slow_tick;

    // timer 2 has no pin and no mode of its own
    assign ctl[TXY_T2].mode     = TXY_MODE_TIMER;
    assign ctl[TXY_T2].edge_sel = 1'b0;
    assign ctl[TXY_T2].stop     = 1'b0;
    assign pin_sync[TXY_T2]     = 1'b0;

    assign ctl[TXY_TX].mode     = txy_mode_t'(q.mode[TXY_MODE_X_LSB +: 2]);
    assign ctl[TXY_TX].edge_sel = q.mode[TXY_EDGE_X_BIT];
    assign ctl[TXY_TX].stop     = q.mode[TXY_STOP_X_BIT];
    assign pin_sync[TXY_TX]     = q.filt[TXY_SYNC_PINX];

    assign ctl[TXY_TY].mode     = txy_mode_t'(q.mode[TXY_MODE_Y_LSB +: 2]);
    assign ctl[TXY_TY].edge_sel = q.mode[TXY_EDGE_Y_BIT];
    assign ctl[TXY_TY].stop     = q.mode[TXY_STOP_Y_BIT];
    assign pin_sync[TXY_TY]     = q.filt[TXY_SYNC_PINY];

    genvar gi;
    generate
        for (gi = 0; gi < TXY_NUM_TIMERS; gi++) begin : g_timer
            assign load[gi] = q.wr_pend & (q.idx == CNT_IDX[gi]);

            txy_timer #(
                .CNT_W     (8),
                .RESET_VAL (TXY_CNT_RST)
            ) u_timer (
                .ref_clk_in  (ref_clk_in),
                .rst_in      (rst_in),
                .clk_en_in   (clk_en_in),
                .tick_in     (tick[gi]),
                .load_in     (load[gi]),
                .load_val_in (hwdata_in[7:0]),
                .ctl_in      (ctl[gi]),
                .pin_in      (pin_sync[gi]),
                .stat_out    (stat[gi])
            );
        end
    endgenerate

    // ahb address phase
    assign addr_ok = (haddr_in[31:TXY_IDX_W+2] == '0);
    assign take    = hsel_in & hready_in & htrans_in[1];

    always_comb begin
        d = q;
        // three-stage pin synchroniser, a change counts once stages 2 and 3 agree
        d.s1       = raw_pins;
        d.s2       = q.s1;
        d.s3       = q.s2;
        d.filt     = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
        d.sub_prev = q.filt[TXY_SYNC_SUB];
        if (base_tick) begin
            d.div = q.div + TXY_DIV_W'(1);
        end

        // data phase of a write
        if (q.wr_pend) begin
            unique case (q.idx)
                TXY_IDX_MODE: d.mode = hwdata_in[7:0];
                TXY_IDX_CSS:  d.css  = hwdata_in[TXY_CSS_W-1:0];
                default:      d.mode = q.mode;
            endcase
        end

        // read data one cycle after the address phase, with one wait state
        if (q.rd_pend) begin
            unique case (q.idx)
                TXY_IDX_T2:   d.hrdata = {24'h000000, stat[TXY_T2].count};
                TXY_IDX_TX:   d.hrdata = {24'h000000, stat[TXY_TX].count};
                TXY_IDX_TY:   d.hrdata = {24'h000000, stat[TXY_TY].count};
                TXY_IDX_MODE: d.hrdata = {24'h000000, q.mode};
                TXY_IDX_CSS:  d.hrdata = {29'h0, q.css};
                default:      d.hrdata = 32'h00000000;
            endcase
        end

        d.wr_pend = take & hwrite_in;
        d.rd_pend = take & ~hwrite_in;
        d.hready  = ~(take & ~hwrite_in);
        if (take) begin
            d.idx = addr_ok ? haddr_in[TXY_IDX_W+1:2] : '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            q.s1       <= '0;
            q.s2       <= '0;
            q.s3       <= '0;
            q.filt     <= '0;
            q.sub_prev <= 1'b0;
            q.div      <= '0;
            q.mode     <= TXY_MODE_RST;
            q.css      <= TXY_CSS_RST;
            q.wr_pend  <= 1'b0;
            q.rd_pend  <= 1'b0;
            q.idx      <= '0;
            q.hready   <= 1'b1;
            q.hrdata   <= 32'h00000000;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    assign hrdata_out    = q.hrdata;
    assign hreadyout_out = q.hready;
    assign hresp_out     = 1'b0;

    assign counter_pin_x_out     = stat[TXY_TX].pin_level;
    assign counter_pin_x_oe_out  = stat[TXY_TX].pin_oe;
    assign counter_pin_y_out     = stat[TXY_TY].pin_level;
    assign counter_pin_y_oe_out  = stat[TXY_TY].pin_oe;
    assign timer_2_irq_out       = stat[TXY_T2].underflow;
    assign timer_x_irq_out       = stat[TXY_TX].underflow;
    assign timer_y_irq_out       = stat[TXY_TY].underflow;
    assign counter_pin_x_irq_out = stat[TXY_TX].pin_irq;
    assign counter_pin_y_irq_out = stat[TXY_TY].pin_irq;

    // only word transfers are meaningful; other sizes act on the low byte
    logic unused_hsize;
    assign unused_hsize = ^hsize_in;

endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import txy_pkg::*;
    localparam int SUB_PER = 8;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0, sub = 1'b0, hrsp, rdy, lsp = 1'b0;
    logic [1:0]  sc = 2'h0;
    logic [1:0]  htr = 2'b00, pin, lvl, oe, pirq;
    logic [2:0]  irq;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd;
    int          mismatches = 0, num_checks = 0, cyc = 0, nx = 0, ny = 0;
    logic [7:0]  cidx [3] = '{TXY_IDX_T2, TXY_IDX_TX, TXY_IDX_TY};
    logic [7:0]  ra [4] = '{TXY_IDX_MODE, TXY_IDX_TX, TXY_IDX_TY, TXY_IDX_CSS};
    logic [7:0]  rv [4] = '{TXY_MODE_RST, TXY_CNT_RST, TXY_CNT_RST, 8'(TXY_CSS_RST)};
    initial forever #2.5 clk = ~clk;
    // subclock with a period of SUB_PER main clocks
    always @(posedge clk) {sub, sc} <= {sub, sc} + 3'h1;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nx  <= nx + int'(pirq[0] === 1'b1);
        ny  <= ny + int'(pirq[1] === 1'b1);
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    txy_board brd (.ref_clk_in(clk), .lvl_in(lvl), .oe_in(oe), .pin_out(pin));
    txy_top DUT (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .hsel_in(hsel), .haddr_in(ha),
        .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hready_in(rdy), .hwdata_in(hwd),
        .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out(hrsp), .sub_clk_in(sub), .low_speed_in(lsp),
        .counter_pin_x_in(pin[0]), .counter_pin_x_out(lvl[0]), .counter_pin_x_oe_out(oe[0]),
        .counter_pin_y_in(pin[1]), .counter_pin_y_out(lvl[1]), .counter_pin_y_oe_out(oe[1]),
        .timer_2_irq_out(irq[0]), .timer_x_irq_out(irq[1]), .timer_y_irq_out(irq[2]),
        .counter_pin_x_irq_out(pirq[0]), .counter_pin_y_irq_out(pirq[1]));
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction
    // other timer of the pair held stopped
    function automatic logic [31:0] mb(input int t, input logic [1:0] m, input logic e);
        return t == 2 ? {24'h0, 1'b0, e, m, 4'h8} : {24'h0, 4'h8, 1'b0, e, m};
    endfunction
    function automatic int per(input logic [7:0] n, input logic f);
        return (n + 1) * (f ? TXY_DIV_FAST : TXY_DIV_SLOW);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int slack = 0);
        num_checks++;
        if (((got === exp) || (slack > 0 && exp - got <= slack)) !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        ha   <= a;
        htr  <= 2'b10;
        hwr  <= wr;
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htr  <= 2'b00;
        hwd  <= wd;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrd;
    endtask
    task automatic wrr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic gap(input int t, output int g);
        do @(negedge clk); while (irq[t] !== 1'b1);
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (irq[t] !== 1'b1);
    endtask
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic [7:0]  v, n;
        int          g;
        int          ax, ay;
        void'($urandom(32'h37882547));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) begin
            bus(1'b0, ad(ra[i]), 0, r);
            chk(r, rv[i], i inside {1, 2});
        end
        wrr(ad(TXY_IDX_MODE), 32'h88);
        repeat (6) begin
            g = $urandom % 3;
            v = $urandom;
            wrr(ad(cidx[g]), {4{v}});
            bus(1'b0, ad(cidx[g]), 0, r);
            chk(r, v, g == 0);
        end
        v = $urandom;
        wrr(ad(TXY_IDX_CSS), {4{v}});
        bus(1'b0, ad(TXY_IDX_CSS), 0, r);
        chk(r, v & 8'h07);
        bus(1'b0, ad(8'h24), 0, r);
        chk(r, 0);
        for (int t = 0; t < 3; t++) begin
            for (int f = 0; f < 2; f++) begin
                n = $urandom % 8;
                wrr(ad(TXY_IDX_CSS), f << (t == 0 ? 2 : t - 1));
                wrr(ad(TXY_IDX_MODE), mb(t, 2'b00, 1'b0));
                wrr(ad(cidx[t]), n);
                gap(t, g);
                chk(g, (t == 0 && f == 1) ? (n + 1) * SUB_PER : per(n, f[0]));
            end
        end
        // low-speed mode: the subclock replaces the main clock ahead of the dividers
        @(posedge clk);
        lsp <= 1'b1;
        wrr(ad(TXY_IDX_CSS), 32'h1);
        wrr(ad(TXY_IDX_MODE), mb(1, 2'b00, 1'b0));
        n = $urandom % 8;
        wrr(ad(TXY_IDX_TX), n);
        gap(1, g);
        chk(g, (n + 1) * TXY_DIV_FAST * SUB_PER);
        @(posedge clk);
        lsp <= 1'b0;
        for (int t = 1; t < 3; t++) begin
            for (int e = 0; e < 2; e++) begin
                wrr(ad(TXY_IDX_MODE), 32'h88);
                wrr(ad(cidx[t]), 32'hff);
                wrr(ad(TXY_IDX_MODE), mb(t, 2'b01, e[0]));
                repeat (3) @(posedge clk);
                chk({oe[t-1], lvl[t-1]}, {1'b1, ~e[0]});
            end
        end
        for (int e = 0; e < 2; e++) begin
            brd.drive(2'b11, 40);
            ax = nx;
            ay = ny;
            wrr(ad(TXY_IDX_MODE), mb(1, 2'b10, e[0]));
            wrr(ad(TXY_IDX_TX), 32'h40);
            brd.drive(2'b00, 40);
            bus(1'b0, ad(TXY_IDX_TX), 0, r);
            chk(r, e ? 32'h3f : 32'h40);
            brd.drive(2'b11, 40);
            bus(1'b0, ad(TXY_IDX_TX), 0, r);
            chk(r, 32'h3f);
            chk(nx - ax, 1);
            chk(ny - ay, 1);
        end
        wrr(ad(TXY_IDX_CSS), 32'h1);
        for (int e = 0; e < 2; e++) begin
            brd.drive({1'b1, e[0]}, 40);
            wrr(ad(TXY_IDX_MODE), mb(1, 2'b11, e[0]));
            wrr(ad(TXY_IDX_TX), 32'hff);
            brd.drive({1'b1, e[0]}, 20);
            bus(1'b0, ad(TXY_IDX_TX), 0, r);
            chk(r, 32'hff);
            brd.drive({1'b1, ~e[0]}, 40);
            brd.drive({1'b1, e[0]}, 20);
            bus(1'b0, ad(TXY_IDX_TX), 0, r);
            chk(r, 32'hff - 19, 3);
        end
        summarize();
    end
endmodule

// ---- test/txy_board.sv ----
`timescale 1ns/1ps
module txy_board (
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] lvl_in,
    input  wire logic [1:0] oe_in,
    output logic      [1:0] pin_out
);
    logic [1:0] drv_q = 2'b11;
    // board lets go of a pin while the block drives it
    assign pin_out = (oe_in & lvl_in) | (~oe_in & drv_q);
    task automatic drive(input logic [1:0] lvl, input int hold);
        @(posedge ref_clk_in);
        drv_q <= lvl;
        repeat (hold) @(posedge ref_clk_in);
    endtask
endmodule

// ---- test/txy_checker.sv ----
`timescale 1ns/1ps
module txy_checker
    import txy_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hwdata_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        counter_pin_x_in,
    input wire logic        counter_pin_x_oe_out,
    input wire logic        counter_pin_y_oe_out,
    input wire logic        timer_2_irq_out,
    input wire logic        timer_x_irq_out,
    input wire logic        counter_pin_x_irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic       tk;
    logic       mw_q;
    logic [7:0] mode_q;
    logic [4:0] stab_q;
    assign tk = hsel_in && hready_in && htrans_in[1];
    // shadow of the mode register and cycles since it was last written
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mw_q   <= 1'b0;
            mode_q <= 8'h00;
            stab_q <= 5'h00;
        end else begin
            mw_q   <= tk && hwrite_in && haddr_in == 32'h8c;
            mode_q <= mw_q ? hwdata_in[7:0] : mode_q;
            stab_q <= mw_q ? 5'h00 : stab_q + 5'(stab_q != 5'h1f);
        end
    end
    a_read_one_wait: assert property (tk && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (tk && hwrite_in |=> hreadyout_out)
        else $error("write stalled");
    a_read_byte_wide: assert property (tk && !hwrite_in |=> ##1 hrdata_out[31:8] == 24'h0)
        else $error("read data above bit 7");
    a_css_upper_zero: assert property (tk && !hwrite_in && haddr_in == 32'ha0 |=> ##1 hrdata_out[7:3] == 5'h0)
        else $error("select bits 7:3 not zero");
    a_x_oe_mode: assert property (stab_q > 5'd3 |-> counter_pin_x_oe_out == (mode_q[1:0] == 2'b01))
        else $error("x pin drive disagrees with mode");
    a_y_oe_mode: assert property (stab_q > 5'd3 |-> counter_pin_y_oe_out == (mode_q[5:4] == 2'b01))
        else $error("y pin drive disagrees with mode");
    a_x_stop_quiet: assert property (stab_q > 5'd3 && mode_q[3] |-> !timer_x_irq_out)
        else $error("stopped x timer underflowed");
    a_x_pin_edge: assert property (counter_pin_x_irq_out && !counter_pin_x_oe_out && stab_q > 5'd15 |->
        $past(counter_pin_x_in, 3) == mode_q[2] && $past(counter_pin_x_in, 10) != mode_q[2])
        else $error("x pin request on wrong edge");
    a_t2_irq_pulse: assert property (timer_2_irq_out |=> !timer_2_irq_out)
        else $error("timer 2 request longer than one cycle");
    cover property (counter_pin_x_irq_out);
    cover property (timer_x_irq_out && mode_q[1:0] == 2'b00);
    cover property (tk && !hwrite_in && haddr_in == 32'ha0);
endmodule
bind txy_top txy_checker u_chk (.*);
